// ---- fpr_chk.sv ----
// fpr_chk: port assertions for fpr_flash_cmd
// assumes the host keeps select high through entry and wake delays
`timescale 1ns/1ps
`default_nettype none
module fpr_chk (
   input wire logic clk_sys_i, // system clock
   input wire logic rst_b_i, // reset, active low
   input wire fpr_pkg::fpr_pin_in_type pin_i, // serial pins
   input wire logic busy_i, // busy cycle
   input wire fpr_pkg::fpr_pin_out_type pin_o, // lane drive
   input wire logic deep_pd_o, // power-down level
   input wire logic soft_reset_o // soft reset pulse
);
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_b_i);
   logic [15:0] hi_cnt_ff, nxt_hi_cnt;
   logic ok_ff, nxt_ok;
   // cycles deselected; a busy-free cycle seen while selected
   always_comb begin
      nxt_hi_cnt = pin_i.cs_b ? hi_cnt_ff + {15'h0000, ~&hi_cnt_ff} : 16'h0000;
      nxt_ok = !pin_i.cs_b && (ok_ff || !busy_i);
   end
   // helper registers
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         hi_cnt_ff <= 16'h0000;
         ok_ff <= 1'b0;
      end else begin
         hi_cnt_ff <= nxt_hi_cnt;
         ok_ff <= nxt_ok;
      end
   end
   chk_oe_code: assert property (pin_o.oe inside {4'h0, 4'h2, 4'h3, 4'hf})
      else $error("bad oe pattern");
   chk_oe_release: assert property (pin_i.cs_b [*5] |-> pin_o.oe == 4'h0)
      else $error("oe held after deselect");
   chk_oe_select: assert property (pin_o.oe != 4'h0 |-> !$past(pin_i.cs_b, 3))
      else $error("oe without select");
   chk_lane_fall: assert property (pin_o.oe != 4'h0 && $changed(pin_o.lane) |-> !$past(pin_i.sclk))
      else $error("lane moved off a falling sclk");
   chk_reset_idle: assert property (disable iff (1'b0) !rst_b_i |-> pin_o.oe == 4'h0 && !deep_pd_o)
      else $error("outputs active in reset");
   chk_sr_pulse: assert property (soft_reset_o |=> !soft_reset_o)
      else $error("soft reset too wide");
   chk_pd_entry: assert property ($rose(deep_pd_o) |-> hi_cnt_ff >= fpr_pkg::POWERDOWN_ENTRY_CYC)
      else $error("power-down entered early");
   chk_wake_delay: assert property ($fell(deep_pd_o) |-> hi_cnt_ff >= fpr_pkg::WAKE_CYC)
      else $error("wake ended early");
   chk_busy_quiet: assert property (!pin_i.cs_b && busy_i && !ok_ff |-> pin_o.oe == 4'h0)
      else $error("drive while busy");
   cov_quad: cover property (pin_o.oe == 4'hf);
   cov_down: cover property ($rose(deep_pd_o));
   cov_sreset: cover property (soft_reset_o);
endmodule // fpr_chk
bind fpr_flash_cmd fpr_chk u_fpr_chk (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .pin_i(pin_i),
   .busy_i(busy_i), .pin_o(pin_o), .deep_pd_o(deep_pd_o), .soft_reset_o(soft_reset_o));
`default_nettype wire

// ---- fpr_flash_cmd.sv ----
// fpr_flash_cmd: otp region read, deep power-down and identification commands
// assumes serial pins are asynchronous and far slower than clk_sys_i (sclk <= clk/8)
// Notes on behaviour
// [R01] otp read takes 24 address bits and 8 dummy bits on rising sclk
// [R02] after the dummy byte otp bytes leave one bit per falling sclk edge
// [R03] byte address increments after each byte; low ten bits wrap to zero
// [R04] host sends opcode, address, dummy, reads, raises select; address picks region 1-3
// [R05] in deep power-down only wake, signature and soft-reset opcodes are taken
// [R06] power-down is opcode alone; entry follows a delay after select rises
// [R07] wake acts only when select rises exactly after the eighth opcode bit; the code also wakes when select rises after a full signature byte
// [R08] reset leaves the device in standby, never in deep power-down
// [R09] wake during the entry delay is immediate; from power-down standby follows the wake delay
// [R10] host keeps select high for the wake delay after a wake
// [R11] signature byte repeats while clocks run; ending after one byte also wakes
// [R12] while a program or erase cycle runs, these commands are rejected
// [R13] new hosts should prefer the three-byte identification read
// [R14] identification read is opcode, two dummy bytes, one address byte
// [R15] identification bytes leave on falling sclk, msb first
// [R16] address 0 gives maker then part code; address 1 reverses the order
// [R17] maker and part codes alternate while select stays low
// [R18] dual-lane identification carries dummy, address and data on two lanes
// [R19] quad-lane identification carries dummy, address and data on four lanes
// [R20] an ignored command drives no lane and changes no state
`timescale 1ns/1ps
`default_nettype none
module fpr_flash_cmd (
   input wire logic clk_sys_i, // 40 MHz system clock
   input wire logic rst_b_i, // async reset, active low
   input wire fpr_pkg::fpr_pin_in_type pin_i, // chip select, serial clock, lanes in
   input wire logic busy_i, // program/erase/status-write cycle running
   input wire logic otp_wr_i, // otp array load strobe
   input wire logic [11:0] otp_waddr_i, // otp array load index
   input wire logic [7:0] otp_wdata_i, // otp array load byte
   output var fpr_pkg::fpr_pin_out_type pin_o, // lane drive and enables
   output logic deep_pd_o, // in deep power-down or waking
   output logic soft_reset_o // one-cycle soft reset request
);
   logic [7:0] otp_mem [0:fpr_pkg::OTP_DEPTH-1];
   fpr_pkg::fpr_pin_in_type sync1_ff, sync2_ff;
   logic sclk_prev_ff, cs_prev_ff;
   fpr_pkg::fpr_ser_state_type st_ff, nxt_st;
   logic [7:0] op_ff, nxt_op;
   logic [5:0] cnt_ff, nxt_cnt;
   logic [31:0] sh_ff, nxt_sh;
   logic [9:0] ptr_ff, nxt_ptr;
   logic [3:0] rgn_ff, nxt_rgn;
   logic rgn_ok_ff, nxt_rgn_ok;
   logic sel_ff, nxt_sel;
   logic [2:0] idx_ff, nxt_idx;
   logic byte_done_ff, nxt_byte_done;
   logic rsten_ff, nxt_rsten;
   fpr_pkg::fpr_pin_out_type out_ff, nxt_out;
   logic srst_ff, nxt_srst;
   fpr_pkg::fpr_pwr_state_type pw_ff, nxt_pw;
   logic [15:0] pw_cnt_ff, nxt_pw_cnt;
   logic sclk_rise, sclk_fall, cs_rise, asleep, wake_evt, dp_evt;
   logic [7:0] op_full, cur_byte;
   logic [2:0] width;

   // lanes used by an opcode
   function automatic logic [2:0] lane_width(input logic [7:0] op);
      case (op)
         fpr_pkg::OPC_DUAL_CODE: lane_width = 3'd2;
         fpr_pkg::OPC_QUAD_CODE: lane_width = 3'd4;
         default: lane_width = 3'd1;
      endcase
   endfunction

   // clocks in the address and dummy phase
   function automatic logic [5:0] addr_clocks(input logic [7:0] op);
      case (op)
         fpr_pkg::OPC_OTP_READ: addr_clocks = fpr_pkg::OTP_ADDR_BITS;
         fpr_pkg::OPC_SIGNATURE: addr_clocks = fpr_pkg::SIG_DUMMY_BITS;
         fpr_pkg::OPC_DUAL_CODE: addr_clocks = fpr_pkg::CODE_ADDR_BITS >> 1;
         fpr_pkg::OPC_QUAD_CODE: addr_clocks = fpr_pkg::CODE_ADDR_BITS >> 2;
         default: addr_clocks = fpr_pkg::CODE_ADDR_BITS;
      endcase
   endfunction

   // two-flop synchronisers for all pins
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync1_ff <= '{cs_b: 1'b1, sclk: 1'b0, lane: 4'h0};
         sync2_ff <= '{cs_b: 1'b1, sclk: 1'b0, lane: 4'h0};
         sclk_prev_ff <= 1'b0;
         cs_prev_ff <= 1'b1;
      end else begin
         sync1_ff <= pin_i;
         sync2_ff <= sync1_ff;
         sclk_prev_ff <= sync2_ff.sclk;
         cs_prev_ff <= sync2_ff.cs_b;
      end
   end

   // otp array load port
   always_ff @(posedge clk_sys_i) begin
      if (otp_wr_i) begin
         otp_mem[otp_waddr_i] <= otp_wdata_i;
      end
   end

   // edge events and current source byte
   always_comb begin
      sclk_rise = sync2_ff.sclk & ~sclk_prev_ff;
      sclk_fall = ~sync2_ff.sclk & sclk_prev_ff;
      cs_rise = sync2_ff.cs_b & ~cs_prev_ff;
      asleep = (pw_ff == fpr_pkg::PW_DOWN) || (pw_ff == fpr_pkg::PW_WAKE);
      op_full = {op_ff[6:0], sync2_ff.lane[0]};
      width = lane_width(op_ff);
      case (op_ff)
         // [R03] region byte at the running pointer
         fpr_pkg::OPC_OTP_READ: cur_byte = rgn_ok_ff ? otp_mem[{2'(rgn_ff[1:0] - 2'd1), ptr_ff}]
                                                     : fpr_pkg::UNMAPPED_BYTE;
         // [R11] signature repeats
         fpr_pkg::OPC_SIGNATURE: cur_byte = fpr_pkg::SIGNATURE_CODE;
         // [R16] order picked by address bit 0
         default: cur_byte = sel_ff ? fpr_pkg::PART_CODE : fpr_pkg::MAKER_CODE;
      endcase
   end

   // serial command sequencer, next values
   always_comb begin
      nxt_st = st_ff;
      nxt_op = op_ff;
      nxt_cnt = cnt_ff;
      nxt_sh = sh_ff;
      nxt_ptr = ptr_ff;
      nxt_rgn = rgn_ff;
      nxt_rgn_ok = rgn_ok_ff;
      nxt_sel = sel_ff;
      nxt_idx = idx_ff;
      nxt_byte_done = byte_done_ff;
      nxt_rsten = rsten_ff;
      nxt_out = out_ff;
      nxt_srst = 1'b0;
      wake_evt = 1'b0;
      dp_evt = 1'b0;
      if (cs_rise) begin
         // [R07] wake only on exact byte boundary or after a full signature
         if (op_ff == fpr_pkg::OPC_SIGNATURE &&
             ((st_ff == fpr_pkg::ST_ADDR && cnt_ff == 6'd0) || (st_ff == fpr_pkg::ST_DATA && byte_done_ff))) begin
            wake_evt = 1'b1;
         end
         if (st_ff == fpr_pkg::ST_HOLD) begin
            case (op_ff)
               // [R06] entry starts at select rise
               fpr_pkg::OPC_POWER_DOWN: dp_evt = 1'b1;
               fpr_pkg::OPC_RESET_EN: nxt_rsten = 1'b1;
               fpr_pkg::OPC_RESET: begin
                  nxt_srst = rsten_ff;
                  nxt_rsten = 1'b0;
               end
               default: nxt_rsten = rsten_ff;
            endcase
         end
      end
      if (sync2_ff.cs_b) begin
         nxt_st = fpr_pkg::ST_OPCODE;
         nxt_cnt = 6'd0;
         nxt_out = '0;
      end else begin
         case (st_ff)
            fpr_pkg::ST_OPCODE: begin
               if (sclk_rise) begin
                  nxt_op = op_full;
                  nxt_cnt = 6'(cnt_ff + 6'd1);
                  if (cnt_ff == 6'd7) begin
                     nxt_cnt = 6'd0;
                     nxt_byte_done = 1'b0;
                     nxt_idx = 3'd0;
                     // [R12] busy cycle rejects everything here
                     if (busy_i) begin
                        nxt_st = fpr_pkg::ST_IGNORE;
                     // [R05] sleep filter
                     end else if (asleep && op_full != fpr_pkg::OPC_SIGNATURE &&
                                  op_full != fpr_pkg::OPC_RESET_EN && op_full != fpr_pkg::OPC_RESET) begin
                        nxt_st = fpr_pkg::ST_IGNORE;
                     end else begin
                        case (op_full)
                           fpr_pkg::OPC_OTP_READ, fpr_pkg::OPC_SIGNATURE, fpr_pkg::OPC_MAKER_PART,
                           fpr_pkg::OPC_DUAL_CODE, fpr_pkg::OPC_QUAD_CODE: nxt_st = fpr_pkg::ST_ADDR;
                           fpr_pkg::OPC_POWER_DOWN, fpr_pkg::OPC_RESET_EN,
                           fpr_pkg::OPC_RESET: nxt_st = fpr_pkg::ST_HOLD;
                           default: nxt_st = fpr_pkg::ST_IGNORE;
                        endcase
                     end
                  end
               end
            end
            fpr_pkg::ST_ADDR: begin
               if (sclk_rise) begin
                  // [R01] [R18] [R19] sample one, two or four lanes
                  case (width)
                     3'd2: nxt_sh = {sh_ff[29:0], sync2_ff.lane[1:0]};
                     3'd4: nxt_sh = {sh_ff[27:0], sync2_ff.lane};
                     default: nxt_sh = {sh_ff[30:0], sync2_ff.lane[0]};
                  endcase
                  nxt_cnt = 6'(cnt_ff + 6'd1);
                  if (nxt_cnt == addr_clocks(op_ff)) begin
                     nxt_st = fpr_pkg::ST_DATA;
                     // [R04] region from bits 15:12, upper and 11:10 zero
                     nxt_ptr = nxt_sh[17:8];
                     nxt_rgn = nxt_sh[23:20];
                     nxt_rgn_ok = (nxt_sh[31:24] == 8'h00) && (nxt_sh[19:18] == 2'b00) &&
                                  (nxt_sh[23:20] >= 4'd1) && (nxt_sh[23:20] <= 4'd3);
                     // [R14] address byte is the last one in
                     nxt_sel = nxt_sh[0];
                  end
               end
            end
            fpr_pkg::ST_DATA: begin
               if (sclk_fall) begin
                  // [R02] [R15] msb first on falling edge
                  case (width)
                     3'd2: nxt_out = '{lane: {2'b00, 2'(cur_byte << idx_ff >> 6)}, oe: 4'h3};
                     3'd4: nxt_out = '{lane: 4'(cur_byte << idx_ff >> 4), oe: 4'hf};
                     default: nxt_out = '{lane: {2'b00, 1'(cur_byte << idx_ff >> 7), 1'b0}, oe: 4'h2};
                  endcase
                  nxt_idx = 3'(idx_ff + width);
                  if (nxt_idx == 3'd0) begin
                     nxt_byte_done = 1'b1;
                     // [R03] ten-bit pointer wraps by itself
                     nxt_ptr = 10'(ptr_ff + 10'd1);
                     // [R17] codes alternate
                     nxt_sel = ~sel_ff;
                  end
               end
            end
            fpr_pkg::ST_HOLD: begin
               // [R07] extra clocks void a bare-opcode command
               if (sclk_rise) begin
                  nxt_st = fpr_pkg::ST_IGNORE;
               end
            end
            // [R20] ignored command keeps lanes off
            fpr_pkg::ST_IGNORE: nxt_out = '0;
            default: nxt_st = fpr_pkg::ST_IGNORE;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_ff <= fpr_pkg::ST_OPCODE;
         op_ff <= 8'h00;
         cnt_ff <= 6'd0;
         sh_ff <= 32'h0;
         ptr_ff <= 10'h0;
         rgn_ff <= 4'h0;
         rgn_ok_ff <= 1'b0;
         sel_ff <= 1'b0;
         idx_ff <= 3'd0;
         byte_done_ff <= 1'b0;
         rsten_ff <= 1'b0;
         out_ff <= '0;
         srst_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         op_ff <= nxt_op;
         cnt_ff <= nxt_cnt;
         sh_ff <= nxt_sh;
         ptr_ff <= nxt_ptr;
         rgn_ff <= nxt_rgn;
         rgn_ok_ff <= nxt_rgn_ok;
         sel_ff <= nxt_sel;
         idx_ff <= nxt_idx;
         byte_done_ff <= nxt_byte_done;
         rsten_ff <= nxt_rsten;
         out_ff <= nxt_out;
         srst_ff <= nxt_srst;
      end
   end

   // power state, next values
   always_comb begin
      nxt_pw = pw_ff;
      nxt_pw_cnt = pw_cnt_ff;
      case (pw_ff)
         fpr_pkg::PW_STANDBY: begin
            if (dp_evt) begin
               nxt_pw = fpr_pkg::PW_ENTER;
               nxt_pw_cnt = fpr_pkg::POWERDOWN_ENTRY_CYC;
            end
         end
         fpr_pkg::PW_ENTER: begin
            nxt_pw_cnt = 16'(pw_cnt_ff - 16'd1);
            // [R09] wake before entry completes is immediate
            if (wake_evt) begin
               nxt_pw = fpr_pkg::PW_STANDBY;
            // [R06] down once the entry delay expires
            end else if (pw_cnt_ff == 16'd1) begin
               nxt_pw = fpr_pkg::PW_DOWN;
            end
         end
         fpr_pkg::PW_DOWN: begin
            // [R09] delayed return to standby
            if (wake_evt) begin
               nxt_pw = fpr_pkg::PW_WAKE;
               nxt_pw_cnt = fpr_pkg::WAKE_CYC;
            end
         end
         fpr_pkg::PW_WAKE: begin
            nxt_pw_cnt = 16'(pw_cnt_ff - 16'd1);
            if (pw_cnt_ff == 16'd1) begin
               nxt_pw = fpr_pkg::PW_STANDBY;
            end
         end
         default: nxt_pw = fpr_pkg::PW_STANDBY;
      endcase
   end

   // [R08] reset lands in standby
   always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pw_ff <= fpr_pkg::PW_STANDBY;
         pw_cnt_ff <= 16'h0;
      end else begin
         pw_ff <= nxt_pw;
         pw_cnt_ff <= nxt_pw_cnt;
      end
   end

   // outputs from flops
   always_comb begin
      pin_o = out_ff;
      deep_pd_o = asleep;
      soft_reset_o = srst_ff;
   end
endmodule // fpr_flash_cmd
`default_nettype wire

// ---- fpr_host.sv ----
// fpr_host: serial host model for the flash command block
// assumes the device answers within four clocks of a falling sclk
`timescale 1ns/1ps
`default_nettype none
module fpr_host (
   input wire logic clk_sys_i, // system clock
   input wire fpr_pkg::fpr_pin_out_type dev_i, // device drive
   output var fpr_pkg::fpr_pin_in_type pin_o, // select, sclk, lanes
   output logic [7:0] rd_byte_o, // byte read back
   output logic rd_valid_o // one-cycle byte strobe
);
   logic [39:0] sh;
   logic [7:0] rb;
   // idle: deselected, clock low
   initial begin
      pin_o = '{cs_b: 1'b1, sclk: 1'b0, lane: 4'h0};
      rd_byte_o = 8'h00;
      rd_valid_o = 1'b0;
   end
   // one sclk phase is five system clocks
   task automatic half();
      repeat (5) @(posedge clk_sys_i);
      #2;
   endtask
   // bits stand across the rising sclk
   task automatic send(input int w);
      for (int j = 0; j < w; j++)
         pin_o.lane[w - 1 - j] = sh[39 - j];
      sh = sh << w;
      half();
      pin_o.sclk = 1'b1;
      half();
      pin_o.sclk = 1'b0;
   endtask
   // whole frame, select rises after the last bit sent or read
   task automatic xfer(input logic [7:0] op, input logic [31:0] arg, input int nbits, input int w,
      input int nb, input bit note);
      sh = {op, arg};
      pin_o.cs_b = 1'b0;
      half();
      repeat (8) send(1);
      repeat (nbits / w) send(w);
      for (int b = 0; b < nb * 8 / w; b++) begin
         pin_o.lane = ~pin_o.lane;
         half();
         for (int j = 0; j < w; j++)
            rb = {rb[6:0], dev_i.lane[(w == 1) ? 1 : w - 1 - j]};
         pin_o.sclk = 1'b1;
         half();
         pin_o.sclk = 1'b0;
         rd_byte_o = rb;
         rd_valid_o = note && ((b + 1) % (8 / w) == 0);
         @(posedge clk_sys_i);
         #2;
         rd_valid_o = 1'b0;
      end
      half();
      pin_o.cs_b = 1'b1;
      half();
      half();
   endtask
endmodule // fpr_host
`default_nettype wire

// ---- fpr_pkg.sv ----
// fpr_pkg: shared constants and pin carriers for the flash command block
// assumes one 40 MHz system clock that oversamples the serial pins
package fpr_pkg;
   // opcodes handled here
   localparam logic [7:0] OPC_OTP_READ = 8'h48;
   localparam logic [7:0] OPC_SIGNATURE = 8'hab;
   localparam logic [7:0] OPC_POWER_DOWN = 8'hb9;
   localparam logic [7:0] OPC_MAKER_PART = 8'h90;
   localparam logic [7:0] OPC_DUAL_CODE = 8'h92;
   localparam logic [7:0] OPC_QUAD_CODE = 8'h94;
   localparam logic [7:0] OPC_RESET_EN = 8'h66;
   localparam logic [7:0] OPC_RESET = 8'h99;
   // identity values, arbitrary neutral codes
   localparam logic [7:0] MAKER_CODE = 8'h5a;
   localparam logic [7:0] PART_CODE = 8'h3c;
   localparam logic [7:0] SIGNATURE_CODE = 8'h2e;
   // read value for an address outside the three regions
   localparam logic [7:0] UNMAPPED_BYTE = 8'hff;
   // address phase lengths in input bits
   localparam logic [5:0] OTP_ADDR_BITS = 6'd32;
   localparam logic [5:0] SIG_DUMMY_BITS = 6'd24;
   localparam logic [5:0] CODE_ADDR_BITS = 6'd24;
   // otp regions
   localparam int OTP_REGION_BYTES = 1024;
   localparam int OTP_REGIONS = 3;
   localparam int OTP_DEPTH = OTP_REGION_BYTES * OTP_REGIONS;
   // timing
   localparam int CLK_MHZ = 40;
   localparam int POWERDOWN_ENTRY_DELAY_NS = 3000;
   localparam int WAKE_DELAY_NS = 8000;
   localparam logic [15:0] POWERDOWN_ENTRY_CYC = 16'((POWERDOWN_ENTRY_DELAY_NS * CLK_MHZ + 999) / 1000);
   localparam logic [15:0] WAKE_CYC = 16'((WAKE_DELAY_NS * CLK_MHZ + 999) / 1000);

   typedef enum {ST_OPCODE, ST_ADDR, ST_DATA, ST_HOLD, ST_IGNORE} fpr_ser_state_type;
   typedef enum {PW_STANDBY, PW_ENTER, PW_DOWN, PW_WAKE} fpr_pwr_state_type;

   // serial pins as seen by the device
   typedef struct packed {
      logic cs_b;
      logic sclk;
      logic [3:0] lane;
   } fpr_pin_in_type;

   // lane drive towards the pads
   typedef struct packed {
      logic [3:0] lane;
      logic [3:0] oe;
   } fpr_pin_out_type;
endpackage

// ---- tb_top.sv ----
// tb_top: self-checking bench for the flash command block
// assumes fpr_host drives the pins and fpr_chk is bound in
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_sys_i = 1'b0;
   logic rst_b_i = 1'b1;
   logic busy_i = 1'b0;
   logic otp_wr_i = 1'b0;
   logic [11:0] otp_waddr_i = 12'h000;
   logic [7:0] otp_wdata_i = 8'h00;
   fpr_pkg::fpr_pin_in_type pin_i;
   fpr_pkg::fpr_pin_out_type pin_o;
   logic deep_pd_o, soft_reset_o, rd_valid;
   int oe_cnt = 0;
   int sr_cnt = 0;
   int mark = 0;
   logic [7:0] rd_byte;
   logic [7:0] mem [0:3071];
   logic [7:0] exp_q [$];
   int miscompares = 0;
   int n_tests = 0;
   int seed = 99530;
   fpr_flash_cmd u_fpr_flash_cmd (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .pin_i(pin_i), .busy_i(busy_i),
      .otp_wr_i(otp_wr_i), .otp_waddr_i(otp_waddr_i), .otp_wdata_i(otp_wdata_i), .pin_o(pin_o),
      .deep_pd_o(deep_pd_o), .soft_reset_o(soft_reset_o));
   fpr_host u_fpr_host (.clk_sys_i(clk_sys_i), .dev_i(pin_o), .pin_o(pin_i), .rd_byte_o(rd_byte),
      .rd_valid_o(rd_valid));
   always #12.5 clk_sys_i = ~clk_sys_i;
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // wait n cycles, then compare the power-down level
   task automatic pd_is(input int n, input logic exp);
      repeat (n) @(posedge clk_sys_i);
      #2;
      check("deep_pd_o", {7'h00, exp}, {7'h00, deep_pd_o});
   endtask
   task automatic cmd(input logic [7:0] op);
      u_fpr_host.xfer(op, 32'h0, 0, 1, 0, 1'b0);
   endtask
   // note the expected bytes, then frame the otp read
   task automatic otp_rd(input logic [3:0] rs, input logic [9:0] a, input int nb, input bit note);
      for (int b = 0; b < nb && note; b++)
         exp_q.push_back(rs inside {4'h1, 4'h2, 4'h3} ? mem[(rs - 1) * 1024 + int'(10'(a + b))] : 8'hff);
      u_fpr_host.xfer(fpr_pkg::OPC_OTP_READ, {8'h00, rs, 2'b00, a, 8'h00}, 32, 1, nb, note);
   endtask
   // drive and pulse counters, read-back against the oldest note
   always @(posedge clk_sys_i) begin
      oe_cnt <= oe_cnt + int'(pin_o.oe !== 4'h0);
      sr_cnt <= sr_cnt + int'(soft_reset_o === 1'b1);
      if (rd_valid === 1'b1)
         check("read byte", exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx, rd_byte);
   end
   // cycle ceiling
   initial begin
      repeat (60000) @(posedge clk_sys_i);
      miscompares++;
      report_and_stop();
   end
   initial begin
      #1;
      rst_b_i = 1'b0;
      for (int k = 0; k < 3072; k++)
         mem[k] = 8'($random(seed));
      repeat (6) @(posedge clk_sys_i);
      #2;
      rst_b_i = 1'b1;
      pd_is(0, 1'b0);
      for (int k = 0; k < 3072; k++) begin
         otp_wr_i = 1'b1;
         otp_waddr_i = 12'(k);
         otp_wdata_i = mem[k];
         @(posedge clk_sys_i);
         #2;
      end
      otp_wr_i = 1'b0;
      otp_rd(4'h2, 10'h3fe, 4, 1'b1);
      for (int k = 1; k < 4; k++)
         otp_rd(4'(k), 10'($random(seed)), 2, 1'b1);
      otp_rd(4'h0, 10'h005, 1, 1'b1);
      $display("test otp done");
      // single, dual and quad id reads; new hosts prefer the three-byte read
      for (int m = 0; m < 6; m++) begin
         for (int b = 0; b < 3; b++)
            exp_q.push_back((m + b) % 2 == 0 ? fpr_pkg::MAKER_CODE : fpr_pkg::PART_CODE);
         u_fpr_host.xfer(8'h90 + 8'(m / 2 * 2), {16'h0, 8'(m % 2), 8'h0}, 24, 1 << (m / 2), 3, 1'b1);
      end
      $display("test ident done");
      cmd(fpr_pkg::OPC_POWER_DOWN);
      pd_is(0, 1'b0);
      pd_is(120, 1'b1);
      mark = oe_cnt;
      u_fpr_host.xfer(fpr_pkg::OPC_MAKER_PART, 32'h0, 24, 1, 1, 1'b0);
      otp_rd(4'h1, 10'h000, 1, 1'b0);
      check("ignored drive", 8'h00, 8'(oe_cnt - mark));
      mark = sr_cnt;
      cmd(fpr_pkg::OPC_RESET_EN);
      cmd(fpr_pkg::OPC_RESET);
      check("sleep soft reset", 8'h01, 8'(sr_cnt - mark));
      pd_is(0, 1'b1);
      u_fpr_host.xfer(fpr_pkg::OPC_SIGNATURE, 32'h0, 1, 1, 0, 1'b0);
      pd_is(330, 1'b1);
      exp_q.push_back(fpr_pkg::SIGNATURE_CODE);
      exp_q.push_back(fpr_pkg::SIGNATURE_CODE);
      u_fpr_host.xfer(fpr_pkg::OPC_SIGNATURE, 32'h0, 24, 1, 2, 1'b1);
      pd_is(0, 1'b1);
      // select held high through the wake delay
      pd_is(320, 1'b0);
      cmd(fpr_pkg::OPC_POWER_DOWN);
      pd_is(130, 1'b1);
      cmd(fpr_pkg::OPC_SIGNATURE);
      pd_is(320, 1'b0);
      cmd(fpr_pkg::OPC_POWER_DOWN);
      cmd(fpr_pkg::OPC_SIGNATURE);
      pd_is(200, 1'b0);
      $display("test power done");
      busy_i = 1'b1;
      mark = oe_cnt;
      otp_rd(4'h1, 10'h000, 2, 1'b0);
      cmd(fpr_pkg::OPC_POWER_DOWN);
      pd_is(130, 1'b0);
      check("busy drive", 8'h00, 8'(oe_cnt - mark));
      busy_i = 1'b0;
      mark = sr_cnt;
      cmd(fpr_pkg::OPC_RESET_EN);
      cmd(fpr_pkg::OPC_RESET);
      check("soft reset", 8'h01, 8'(sr_cnt - mark));
      check("notes left", 8'h00, 8'(exp_q.size()));
      $display("test busy done");
      report_and_stop();
   end
endmodule // tb_top
`default_nettype wire
